//--- hdl/swl_defines.svh
// Offsets, field positions, reset values and timing constants of the link
`ifndef SWL_DEFINES_SVH
`define SWL_DEFINES_SVH

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define SWL_CMD_RESET 8'hb4
`define SWL_CMD_BIT 8'h87
`define SWL_CMD_PORT_CFG 8'hc3
`define SWL_CMD_DEV_CFG 8'hd2

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SWL_ADDR_CMD 4'h0
`define SWL_ADDR_PARAM 4'h1
`define SWL_ADDR_STATUS 4'h2
`define SWL_ADDR_DEVCFG 4'h3
`define SWL_ADDR_PTR 4'h4
`define SWL_ADDR_TIMING 4'h5

// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define SWL_ST_BUSY 0
`define SWL_ST_PRESENCE 1
`define SWL_ST_SHORT 2
`define SWL_ST_RESULT 5
`define SWL_ST_DIR 7

// ---------------------------------------------------------------
// Device configuration fields and reset value
// ---------------------------------------------------------------
`define SWL_CFG_APU 0
`define SWL_CFG_SPU 2
`define SWL_CFG_SPEED 3
`define SWL_CFG_RESET 8'h00

// ---------------------------------------------------------------
// Port configuration control byte fields
// ---------------------------------------------------------------
`define SWL_PC_SEL_HI 7
`define SWL_PC_SEL_LO 5
`define SWL_PC_OD 4
`define SWL_PC_VAL_HI 3
`define SWL_PC_CODE_RESET 4'h6

// ---------------------------------------------------------------
// Timing, nanoseconds, and cycle counts at 100 MHz
// ---------------------------------------------------------------
`define SWL_CLK_NS 10
`define SWL_START_MAX_NS 262
`define SWL_START_CYC (`SWL_START_MAX_NS / `SWL_CLK_NS)
`define SWL_SLOT_STD_NS 70000
`define SWL_SLOT_OD_NS 10000
`define SWL_W1L_STD_NS 6000
`define SWL_W1L_OD_NS 1000
`define SWL_MSR_STD_NS 15000
`define SWL_MSR_OD_NS 2000
`define SWL_SI_STD_NS 8000
`define SWL_SI_OD_NS 1000
`define SWL_RSTL_BASE_NS 440000
`define SWL_RSTL_STEP_NS 20000
`define SWL_MSP_BASE_NS 58000
`define SWL_MSP_STEP_NS 2000
`define SWL_W0L_BASE_NS 52000
`define SWL_W0L_STEP_NS 2000
`define SWL_REC_NS 2750
`define SWL_REC_STEP_NS 2500
`endif

//--- hdl/swl_pkg.sv
// Types shared by the single-wire reset and bit-slot engine
package swl_pkg;
   typedef enum logic [2:0]
   {
      SWL_IDLE = 3'b000,
      SWL_WAIT = 3'b001,
      SWL_LOW = 3'b011,
      SWL_HIGH = 3'b010,
      SWL_REC = 3'b110
   } swl_state_type;

   typedef enum logic [1:0]
   {
      SWL_OP_RESET = 2'b00,
      SWL_OP_BIT = 2'b01
   } swl_op_type;
endpackage

//--- hdl/swl_timing_ram.sv
// Small memory holding the adjustable timing codes per speed
`timescale 1ns/10ps
`include "swl_defines.svh"
module swl_timing_ram
#(
   parameter int DEPTH = 16,
   parameter int WIDTH = 4
)
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Write side
   input wire logic wr_en_i,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   // Read side
   input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [WIDTH-1:0] rd_q;
   logic [WIDTH-1:0] rd_d;

   initial
   begin
      if (DEPTH < 2 || WIDTH < 1)
      begin
         $error("swl_timing_ram: bad geometry");
      end
   end

   always_comb
   begin
      mem_d = mem_q;
      if (wr_en_i)
      begin
         mem_d[wr_addr_i] = wr_data_i;
      end
      rd_d = mem_q[rd_addr_i];
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_q[i] <= WIDTH'(`SWL_PC_CODE_RESET);
         end
         rd_q <= '0;
      end
      else
      begin
         mem_q <= mem_d;
         rd_q <= rd_d;
      end
   end

   assign rd_data_o = rd_q;
endmodule

//--- hdl/swl_engine.sv
// Single-wire reset and single-bit slot engine with register port
// Summary of operation
// - Command b4h without parameter makes one reset/presence cycle.
// - Reset cycle samples line at short and presence times into flags.
// - Reset code while busy is refused and ignored.
// - Reset line activity starts within 262.5 ns of the command.
// - Reset finishes within twice reset low time plus 262.5 ns.
// - Busy holds twice reset low; flags update at low plus sample time.
// - After reset the read pointer selects the status register.
// - Command 87h plus bit byte makes exactly one time slot.
// - Slot value is bit 7 of the bit byte, others ignored.
// - Line sampled at bit sample time into single bit result.
// - Bit command while busy is refused and discarded.
// - Slot starts within 262.5 ns, ends within the longer of slot and write-zero low plus 262.5 ns.
// - Busy held for the slot plus recovery time; direction flag may change.
// - After a bit command the read pointer selects status.
// - Slot honours speed, pullup settings and port timing values.
// - Each timing keeps standard and overdrive values, chosen by bit.
`timescale 1ns/10ps
`include "swl_defines.svh"
module swl_engine
#(
   parameter int ADDR_W = 4,
   parameter int SCALE = 1
)
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic cmd_ack_o,
   output logic cmd_nak_o,
   // Single-wire line
   input wire logic line_i,
   output logic line_o,
   output logic line_oe_o,
   output logic strong_pullup_o,
   output logic active_pullup_o
);
   initial
   begin
      if (ADDR_W < 3 || SCALE < 1)
      begin
         $error("swl_engine: bad parameter");
      end
   end

   // ---------------------------------------------------------------
   // Cycle conversion
   // ---------------------------------------------------------------
   function automatic logic [19:0] ns2cyc(input int ns);
      int c;
      c = (ns + `SWL_CLK_NS - 1) / `SWL_CLK_NS / SCALE;
      if (c < 1)
      begin
         c = 1;
      end
      return 20'(c);
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   swl_pkg::swl_state_type st_q, st_d;
   swl_pkg::swl_op_type op_q, op_d;
   logic [19:0] cnt_q, cnt_d;
   logic busy_q, busy_d;
   logic ppd_q, ppd_d;
   logic sd_q, sd_d;
   logic sbr_q, sbr_d;
   logic dir_q, dir_d;
   logic val_q, val_d;
   logic pend_bit_q, pend_bit_d;
   logic [7:0] cfg_q, cfg_d;
   logic [ADDR_W-1:0] ptr_q, ptr_d;
   logic [7:0] rdata_q, rdata_d;
   logic ack_q, ack_d;
   logic nak_q, nak_d;
   logic [7:0] pc_code;
   logic pc_wr;
   logic [3:0] wr_addr, rd_addr;
   logic [3:0] code;
   logic [2:0] sel_q, sel_d;
   logic od;

   assign od = cfg_q[`SWL_CFG_SPEED];
   assign pc_wr = wr_i && addr_i == ADDR_W'(`SWL_ADDR_TIMING);
   assign pc_code = wdata_i;
   // Overdrive bit picks which copy is written
   assign wr_addr = {pc_code[6:5], pc_code[`SWL_PC_OD], pc_code[7]};
   assign rd_addr = {sel_q[1:0], od, sel_q[2]};

   swl_timing_ram #(.DEPTH(16), .WIDTH(4)) u_ram
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .wr_en_i(pc_wr && !busy_q),
      .wr_addr_i(wr_addr),
      .wr_data_i(pc_code[`SWL_PC_VAL_HI:0]),
      .rd_addr_i(rd_addr),
      .rd_data_o(code)
   );

   // Selected timing value in cycles, speed scaled for overdrive except recovery
   function automatic logic [19:0] tval(input logic [2:0] sel,
                                        input logic [3:0] c,
                                        input logic o);
      int ns;
      case (sel)
         3'd0: ns = `SWL_RSTL_BASE_NS + int'(c) * `SWL_RSTL_STEP_NS;
         3'd1: ns = `SWL_MSP_BASE_NS + int'(c) * `SWL_MSP_STEP_NS;
         3'd2: ns = `SWL_W0L_BASE_NS + int'(c) * `SWL_W0L_STEP_NS;
         default: ns = `SWL_REC_NS + int'(c) * `SWL_REC_STEP_NS;
      endcase
      if (o && sel != 3'd3)
      begin
         ns = ns / 10;
      end
      return ns2cyc(ns);
   endfunction

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   logic [19:0] t_sel;
   assign t_sel = tval(sel_q, code, od);

   always_comb
   begin
      st_d = st_q;
      op_d = op_q;
      cnt_d = cnt_q + 20'd1;
      busy_d = busy_q;
      ppd_d = ppd_q;
      sd_d = sd_q;
      sbr_d = sbr_q;
      dir_d = dir_q;
      val_d = val_q;
      pend_bit_d = pend_bit_q;
      cfg_d = cfg_q;
      ptr_d = ptr_q;
      sel_d = sel_q;
      ack_d = 1'b0;
      nak_d = 1'b0;
      rdata_d = 8'h00;
      if (rd_i)
      begin
         case (addr_i)
            ADDR_W'(`SWL_ADDR_STATUS):
               rdata_d = {dir_q, 1'b0, sbr_q, 2'b00, sd_q, ppd_q, busy_q};
            ADDR_W'(`SWL_ADDR_DEVCFG): rdata_d = cfg_q;
            ADDR_W'(`SWL_ADDR_PTR): rdata_d = 8'(ptr_q);
            default: rdata_d = 8'h00;
         endcase
      end
      if (wr_i && addr_i == ADDR_W'(`SWL_ADDR_DEVCFG) && !busy_q)
      begin
         cfg_d = wdata_i;
      end
      if (wr_i && addr_i == ADDR_W'(`SWL_ADDR_CMD))
      begin
         if (busy_q)
         begin
            nak_d = 1'b1;
            pend_bit_d = 1'b0;
         end
         else if (wdata_i == `SWL_CMD_RESET)
         begin
            ack_d = 1'b1;
            busy_d = 1'b1;
            op_d = swl_pkg::SWL_OP_RESET;
            ptr_d = ADDR_W'(`SWL_ADDR_STATUS);
            sel_d = 3'd0;
            st_d = swl_pkg::SWL_WAIT;
            cnt_d = '0;
         end
         else if (wdata_i == `SWL_CMD_BIT)
         begin
            ack_d = 1'b1;
            pend_bit_d = 1'b1;
         end
         else
         begin
            nak_d = 1'b1;
         end
      end
      if (wr_i && addr_i == ADDR_W'(`SWL_ADDR_PARAM) && pend_bit_q)
      begin
         ack_d = 1'b1;
         pend_bit_d = 1'b0;
         val_d = wdata_i[7];
         busy_d = 1'b1;
         op_d = swl_pkg::SWL_OP_BIT;
         ptr_d = ADDR_W'(`SWL_ADDR_STATUS);
         sel_d = 3'd2;
         st_d = swl_pkg::SWL_WAIT;
         cnt_d = '0;
      end
      case (st_q)
         swl_pkg::SWL_IDLE:
         begin
         end
         // Start delay of 25 cycles; the timing memory presents its code meanwhile
         swl_pkg::SWL_WAIT:
         begin
            if (cnt_q >= 20'(`SWL_START_CYC) - 20'd2)
            begin
               st_d = swl_pkg::SWL_LOW;
               cnt_d = '0;
            end
         end
         swl_pkg::SWL_LOW:
         begin
            if (op_q == swl_pkg::SWL_OP_RESET)
            begin
               if (cnt_q + 20'd1 >= t_sel)
               begin
                  st_d = swl_pkg::SWL_HIGH;
                  sel_d = 3'd1;
                  cnt_d = '0;
               end
            end
            else if (val_q ? cnt_q + 20'd1 >=
                     ns2cyc(od ? `SWL_W1L_OD_NS : `SWL_W1L_STD_NS)
                     : cnt_q + 20'd1 >= t_sel)
            begin
               st_d = swl_pkg::SWL_HIGH;
            end
            if (op_q == swl_pkg::SWL_OP_BIT && cnt_q + 20'd1 ==
                ns2cyc(od ? `SWL_MSR_OD_NS : `SWL_MSR_STD_NS))
            begin
               sbr_d = line_i;
               dir_d = line_i;
            end
         end
         swl_pkg::SWL_HIGH:
         begin
            if (op_q == swl_pkg::SWL_OP_RESET)
            begin
               if (cnt_q + 20'd1 ==
                   ns2cyc(od ? `SWL_SI_OD_NS : `SWL_SI_STD_NS))
               begin
                  sd_d = !line_i;
               end
               if (cnt_q + 20'd1 == t_sel && sel_q == 3'd1)
               begin
                  ppd_d = !line_i;
                  sel_d = 3'd0;
               end
               if (sel_q == 3'd0 && cnt_q + 20'd1 >= t_sel)
               begin
                  busy_d = 1'b0;
                  st_d = swl_pkg::SWL_IDLE;
               end
            end
            else
            begin
               if (cnt_q + 20'd1 ==
                   ns2cyc(od ? `SWL_MSR_OD_NS : `SWL_MSR_STD_NS))
               begin
                  sbr_d = line_i;
                  dir_d = line_i;
               end
               if (cnt_q + 20'd1 >=
                   ns2cyc(od ? `SWL_SLOT_OD_NS : `SWL_SLOT_STD_NS))
               begin
                  st_d = swl_pkg::SWL_REC;
                  sel_d = 3'd3;
                  cnt_d = '0;
               end
            end
         end
         swl_pkg::SWL_REC:
         begin
            if (cnt_q + 20'd1 >= t_sel)
            begin
               busy_d = 1'b0;
               st_d = swl_pkg::SWL_IDLE;
            end
         end
         default:
         begin
            st_d = swl_pkg::SWL_IDLE;
            busy_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         st_q <= swl_pkg::SWL_IDLE;
         op_q <= swl_pkg::SWL_OP_RESET;
         cnt_q <= '0;
         busy_q <= 1'b0;
         ppd_q <= 1'b0;
         sd_q <= 1'b0;
         sbr_q <= 1'b0;
         dir_q <= 1'b0;
         val_q <= 1'b0;
         pend_bit_q <= 1'b0;
         cfg_q <= `SWL_CFG_RESET;
         ptr_q <= ADDR_W'(`SWL_ADDR_STATUS);
         sel_q <= 3'd0;
         rdata_q <= 8'h00;
         ack_q <= 1'b0;
         nak_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         op_q <= op_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         ppd_q <= ppd_d;
         sd_q <= sd_d;
         sbr_q <= sbr_d;
         dir_q <= dir_d;
         val_q <= val_d;
         pend_bit_q <= pend_bit_d;
         cfg_q <= cfg_d;
         ptr_q <= ptr_d;
         sel_q <= sel_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
         nak_q <= nak_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Line is open drain: only ever driven low
   assign line_o = 1'b0;
   assign line_oe_o = st_q == swl_pkg::SWL_LOW;
   assign active_pullup_o = cfg_q[`SWL_CFG_APU] &&
                            st_q != swl_pkg::SWL_LOW;
   assign strong_pullup_o = cfg_q[`SWL_CFG_SPU] && !busy_q &&
                            op_q == swl_pkg::SWL_OP_BIT;
   assign rdata_o = rdata_q;
   assign cmd_ack_o = ack_q;
   assign cmd_nak_o = nak_q;
endmodule

//--- dv/swl_engine_props.sv
// Concurrent checks of the engine's register and line ports
`timescale 1ns/10ps
module swl_engine_props
#(
   parameter int ADDR_W = 4,
   parameter int SCALE = 1
)
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic cmd_ack_o,
   input wire logic cmd_nak_o,
   // Single-wire line
   input wire logic line_i,
   input wire logic line_o,
   input wire logic line_oe_o,
   input wire logic strong_pullup_o,
   input wire logic active_pullup_o
);
   localparam int RST_MIN = 44000 / SCALE;
   localparam int RST_MAX = 74000 / SCALE + 1;
   localparam int W1_MAX = 600 / SCALE + 2;
   localparam int W0_MIN = 5200 / SCALE;
   localparam int W0_MAX = 7000 / SCALE + 2;
   logic [15:0] run_q;
   logic [ADDR_W-1:0] lw_a_q;
   logic [7:0] lw_d_q;
   logic op_q;
   logic v_q;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   // ---------------------------------------------------------------
   // Low-time counter
   // ---------------------------------------------------------------
   // Only an accepted command may pick the bound, so refused writes
   // arriving mid-cycle cannot confuse the length checks
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         run_q <= 16'h0000;
         lw_a_q <= '0;
         lw_d_q <= 8'h00;
         op_q <= 1'b0;
         v_q <= 1'b0;
      end
      else
      begin
         run_q <= line_oe_o ? run_q + 16'h0001 : 16'h0000;
         if (wr_i)
         begin
            lw_a_q <= addr_i;
            lw_d_q <= wdata_i;
         end
         if (cmd_ack_o && lw_a_q == '0)
            op_q <= (lw_d_q == 8'h87);
         if (cmd_ack_o && lw_a_q == ADDR_W'(1))
            v_q <= lw_d_q[7];
      end
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_rst_start;
      (wr_i && addr_i == '0 && wdata_i == 8'hb4) ##1 cmd_ack_o
         |-> ##[0:26] line_oe_o;
   endproperty
   a_rst_start: assert property (p_rst_start)
      else $error("reset activity started late");
   property p_bit_start;
      (wr_i && addr_i == ADDR_W'(1)) ##1 cmd_ack_o |-> ##[0:26] line_oe_o;
   endproperty
   a_bit_start: assert property (p_bit_start)
      else $error("slot activity started late");
   property p_excl;
      not (cmd_ack_o && cmd_nak_o);
   endproperty
   a_excl: assert property (p_excl)
      else $error("accept and refuse together");
   property p_unknown;
      wr_i && addr_i == '0 && !(wdata_i inside {8'hb4, 8'h87, 8'hc3, 8'hd2})
         |=> cmd_nak_o;
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("unknown code not refused");
   property p_ack_cause;
      cmd_ack_o |-> $past(wr_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("accept without a write");
   property p_drive;
      line_o == 1'b0;
   endproperty
   a_drive: assert property (p_drive)
      else $error("line driven high");
   property p_apu;
      active_pullup_o |-> !line_oe_o;
   endproperty
   a_apu: assert property (p_apu)
      else $error("pullup while driving low");
   property p_rst_len;
      $fell(line_oe_o) && !op_q |-> run_q >= RST_MIN && run_q <= RST_MAX;
   endproperty
   a_rst_len: assert property (p_rst_len)
      else $error("reset low time out of range");
   property p_w1;
      $fell(line_oe_o) && op_q && v_q |-> run_q >= 1 && run_q <= W1_MAX;
   endproperty
   a_w1: assert property (p_w1)
      else $error("write-one low time out of range");
   property p_w0;
      $fell(line_oe_o) && op_q && !v_q |-> run_q >= W0_MIN && run_q <= W0_MAX;
   endproperty
   a_w0: assert property (p_w0)
      else $error("write-zero low time out of range");
endmodule
bind swl_engine swl_engine_props #(.ADDR_W(ADDR_W), .SCALE(SCALE))
   swl_engine_props_inst (.clock_i(clock_i), .rst_i(rst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .cmd_ack_o(cmd_ack_o), .cmd_nak_o(cmd_nak_o),
   .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o),
   .strong_pullup_o(strong_pullup_o), .active_pullup_o(active_pullup_o));

//--- dv/swl_slave_model.sv
// Behavioural slave on the open-drain line: presence, read bits, short
`timescale 1ns/10ps
module swl_slave_model
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Line and behaviour select: 0 absent, 1 present, 2 shorted
   input wire logic line_i,
   input wire logic [1:0] mode_i,
   input wire logic read_bit_i,
   output logic pull_low_o
);
   logic line_q;
   int low_q;
   int pres_q;
   int hold_q;
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         line_q <= 1'b1;
         low_q <= 0;
         pres_q <= 0;
         hold_q <= 0;
      end
      else
      begin
         line_q <= line_i;
         low_q <= line_i ? 0 : low_q + 1;
         // Long low seen: answer after a short wait
         if (line_i && !line_q && low_q > 300 && mode_i == 2'd1)
            pres_q <= 215;
         else if (pres_q > 0)
            pres_q <= pres_q - 1;
         // A zero read holds the line low past the sample
         if (!line_i && line_q && !read_bit_i)
            hold_q <= 30;
         else if (hold_q > 0)
            hold_q <= hold_q - 1;
      end
   end
   assign pull_low_o = mode_i == 2'd2 || (pres_q > 0 && pres_q < 200) ||
      (hold_q > 0 && mode_i == 2'd1);
endmodule

//--- dv/swl_engine_bench.sv
// Self-checking bench for the single-wire reset and bit-slot engine
`timescale 1ns/10ps
module swl_engine_bench;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic cmd_ack_o, cmd_nak_o, line_o, line_oe_o;
   logic strong_pullup_o, active_pullup_o, pull_low;
   logic [1:0] mode = 2'd1;
   logic read_bit = 1'b1;
   int checks = 0;
   int bad_count = 0;
   // Pull-up wins unless someone drives low
   wire line = !(line_oe_o && !line_o) && !pull_low;
   swl_engine #(.ADDR_W(4), .SCALE(100)) swl_engine_inst (.clock_i(clock_i),
      .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .cmd_ack_o(cmd_ack_o),
      .cmd_nak_o(cmd_nak_o), .line_i(line), .line_o(line_o),
      .line_oe_o(line_oe_o), .strong_pullup_o(strong_pullup_o),
      .active_pullup_o(active_pullup_o));
   swl_slave_model swl_slave_model_inst (.clock_i(clock_i), .rst_i(rst_i),
      .line_i(line), .mode_i(mode), .read_bit_i(read_bit),
      .pull_low_o(pull_low));
   initial
   begin
      forever #5 clock_i = !clock_i;
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic results();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic near(input int n, input int e);
      chk(16'(n >= e - 2 && n <= e + 2), 16'h0001);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d,
      output logic [1:0] r);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      #1 r = {cmd_ack_o, cmd_nak_o};
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // Length of the next drive-low interval, in clock cycles
   task automatic meas(output int n);
      int i;
      n = 0;
      for (i = 0; i < 200 && line_oe_o !== 1'b1; i++)
         @(posedge clock_i) #1;
      if (i == 200)
      begin
         bad_count++;
         results();
      end
      while (line_oe_o === 1'b1 && n < 2000)
      begin
         @(posedge clock_i) #1;
         n++;
      end
   endtask
   task automatic idle();
      logic [7:0] s;
      for (int i = 0; i < 3000; i++)
      begin
         rd(4'h2, s);
         if (s[0] === 1'b0)
            return;
      end
      bad_count++;
      results();
   endtask
   task automatic do_reset(input int e, input logic [7:0] st);
      logic [1:0] r;
      logic [7:0] s;
      int n;
      wr(4'h0, 8'hb4, r);
      chk(16'(r), 16'h0002);
      rd(4'h2, s);
      chk(16'(s[0]), 16'h0001);
      meas(n);
      near(n, e);
      idle();
      rd(4'h2, s);
      chk(16'(s[2:0]), 16'(st[2:0]));
      rd(4'h4, s);
      chk(16'(s), 16'h0002);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic s_flags();
      do_reset(560, 8'h02);
      mode = 2'd0;
      do_reset(560, 8'h00);
      mode = 2'd2;
      do_reset(560, 8'h06);
      mode = 2'd1;
   endtask
   task automatic s_refuse();
      logic [1:0] r;
      int n;
      wr(4'h0, 8'hb4, r);
      wr(4'h0, 8'h87, r);
      chk(16'(r), 16'h0001);
      wr(4'h1, 8'h80, r);
      chk(16'(r), 16'h0000);
      wr(4'h0, 8'hb4, r);
      chk(16'(r), 16'h0001);
      meas(n);
      near(n, 560);
      idle();
      repeat (100)
      begin
         @(posedge clock_i) #1;
         chk(16'(line_oe_o), 16'h0000);
      end
      wr(4'h0, 8'h55, r);
      chk(16'(r), 16'h0001);
   endtask
   task automatic s_bits();
      logic [7:0] b [3] = '{8'hff, 8'h80, 8'h7f};
      logic rb [3] = '{1'b1, 1'b0, 1'b1};
      int len [3] = '{6, 6, 64};
      logic [1:0] r;
      logic [7:0] s;
      int n;
      for (int i = 0; i < 3; i++)
      begin
         read_bit = rb[i];
         wr(4'h0, 8'h87, r);
         chk(16'(r), 16'h0002);
         wr(4'h1, b[i], r);
         chk(16'(r), 16'h0002);
         meas(n);
         near(n, len[i]);
         idle();
         rd(4'h2, s);
         chk(16'(s & 8'ha0),
             (b[i][7] & rb[i]) ? 16'h00a0 : 16'h0000);
         rd(4'h4, s);
         chk(16'(s), 16'h0002);
      end
      read_bit = 1'b1;
   endtask
   task automatic s_timing();
      logic [1:0] r;
      wr(4'h5, 8'h10, r);
      do_reset(560, 8'h02);
      wr(4'h5, 8'h00, r);
      do_reset(440, 8'h02);
      wr(4'h5, 8'h06, r);
   endtask
   task automatic s_pullup();
      logic [1:0] r;
      logic [7:0] s;
      int n;
      wr(4'h3, 8'h05, r);
      @(posedge clock_i) #1;
      chk(16'(active_pullup_o), 16'h0001);
      wr(4'hf, 8'hff, r);
      rd(4'hf, s);
      rd(4'h3, s);
      chk(16'(s), 16'h0005);
      wr(4'h0, 8'h87, r);
      wr(4'h1, 8'hff, r);
      meas(n);
      idle();
      chk(16'(strong_pullup_o), 16'h0001);
      wr(4'h3, 8'h00, r);
      @(posedge clock_i) #1;
      chk(16'(active_pullup_o), 16'h0000);
   endtask
   initial
   begin
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      s_flags();
      s_refuse();
      s_bits();
      s_timing();
      s_pullup();
      results();
   end
endmodule
